/* rtl/input_flags_pkg.sv */
// Purpose: constants and types for the debounced input level and change flag block
// Assumes: AHB-Lite word access, 200 MHz hclk
// Notes: register index times four gives the byte address
// Functional notes
// - four words show present debounced channel levels
// - level words descend, channel 63 at top
// - flag words use the same channel order
// - flag set on enabled change only
// - writing zero clears that flag bit
// - control bit 13 one clears all flags
// - control bit 13 returns to zero itself
// - edge select: off, falling, rising, both
// - filter time is setting plus one milliseconds
package input_flags_pkg;
    // ==========================================
    // register indices (byte address = index * 4)
    localparam logic [9:0] IDX_BOARD_CONTROL_STATUS = 10'h000;
    localparam logic [9:0] IDX_INPUT_LEVEL_CH63_48 = 10'h008;
    localparam logic [9:0] IDX_INPUT_LEVEL_CH47_32 = 10'h00a;
    localparam logic [9:0] IDX_INPUT_LEVEL_CH31_16 = 10'h00c;
    localparam logic [9:0] IDX_INPUT_LEVEL_CH15_0 = 10'h00e;
    localparam logic [9:0] IDX_CHANGE_FLAGS_CH63_48 = 10'h010;
    localparam logic [9:0] IDX_CHANGE_FLAGS_CH47_32 = 10'h012;
    localparam logic [9:0] IDX_CHANGE_FLAGS_CH31_16 = 10'h014;
    localparam logic [9:0] IDX_CHANGE_FLAGS_CH15_0 = 10'h016;
    localparam logic [9:0] IDX_CHANNEL_CONFIG_BASE = 10'h020;
    localparam logic [9:0] IDX_CHANNEL_CONFIG_LAST = 10'h09e;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h100;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h102;
    localparam logic [9:0] IDX_WORD_STEP = 10'h002;
    // ==========================================
    // field positions
    localparam int CSR_CLEAR_FLAGS_BIT = 13;
    localparam int EDGE_SELECT_HIGH_BIT = 15;
    localparam int EDGE_SELECT_LOW_BIT = 14;
    localparam int FILTER_TIME_MSB = 9;
    localparam int IRQ_CHANGE_BIT = 0;
    localparam int IRQ_OVERRUN_BIT = 1;
    localparam int NUM_CHANNELS = 64;
    localparam int WORD_BITS = 16;
    // ==========================================
    // reset values
    localparam logic [63:0] LEVEL_RESET = 64'h0;
    localparam logic [63:0] FLAGS_RESET = 64'h0;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // ==========================================
    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int FILTER_STEP_NS = 1000000;
    localparam int MS_CYCLES_DEFAULT = (FILTER_STEP_NS * 1000) / CLK_PERIOD_PS;
    // ==========================================
    // types
    typedef enum logic [1:0] {
        edge_off,
        edge_falling,
        edge_rising,
        edge_both
    } edge_select_e;

    typedef struct packed {
        edge_select_e edge_sel;
        logic [FILTER_TIME_MSB:0] filter_time_select;
    } channel_config_s;

    typedef struct packed {
        logic in_range;
        logic write;
        logic [9:0] index;
    } bus_request_s;

    typedef enum logic {
        st_idle,
        st_busy
    } bus_state_e;
endpackage

/* rtl/input_change_flags.sv */
// Purpose: debounced level words and sticky change flags for 64 field inputs
// Assumes: field inputs synchronous to hclk; single-word AHB-Lite transfers
// Notes: every transfer takes one wait state; response is always OKAY
`timescale 1ns/1ps
`default_nettype none
module input_change_flags
    import input_flags_pkg::*;
#(
    parameter int unsigned ms_cycles = MS_CYCLES_DEFAULT
) (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // async reset, low active
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size, words only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic [63:0] field_in, // raw input channel levels
    output logic [63:0] change_strobe, // one-cycle change detected per channel
    output logic irq // level interrupt
);
    // ==========================================
    // helpers
    function automatic logic [15:0] word_of(input logic [63:0] vec, input int k);
        word_of = vec[63 - 16 * k -: 16];
    endfunction

    function automatic logic [5:0] channel_of(input logic [9:0] idx);
        logic [9:0] off;
        off = idx - IDX_CHANNEL_CONFIG_BASE;
        channel_of = off[6:1];
    endfunction

    // ==========================================
    // state
    bus_state_e state, next_state;
    bus_request_s req, next_req;
    logic [31:0] next_hrdata;
    logic next_hreadyout;
    logic [31:0] read_data;

    logic [63:0] debounced, next_debounced;
    logic [63:0] flags, next_flags;
    logic [10:0] count [NUM_CHANNELS];
    logic [10:0] next_count [NUM_CHANNELS];
    channel_config_s cfg [NUM_CHANNELS];
    channel_config_s next_cfg [NUM_CHANNELS];
    logic clear_pending, next_clear_pending;
    logic [1:0] irq_status, next_irq_status;
    logic [1:0] irq_mask, next_irq_mask;
    logic next_irq;
    logic [63:0] change_set;
    logic [31:0] tick_count, next_tick_count;
    logic ms_tick;
    logic wr;
    logic [9:0] widx;

    assign wr = (state == st_busy) && req.write && req.in_range;
    assign widx = req.index;
    assign ms_tick = (tick_count == ms_cycles - 1);

    // ==========================================
    // bus slave
    always_comb begin
        next_state = state;
        next_req = req;
        next_hrdata = hrdata;
        next_hreadyout = hreadyout;
        unique case (state)
            st_idle: begin
                if (hsel && htrans[1] && hready) begin
                    next_req.in_range = (haddr[31:12] == 20'h00000);
                    next_req.write = hwrite;
                    next_req.index = haddr[11:2];
                    next_hreadyout = 1'b0;
                    next_state = st_busy;
                end
            end
            st_busy: begin
                // one wait state lets read data come from a flop
                if (!req.write) begin
                    next_hrdata = read_data;
                end
                next_hreadyout = 1'b1;
                next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= st_idle;
            req <= '0;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            state <= next_state;
            req <= next_req;
            hrdata <= next_hrdata;
            hreadyout <= next_hreadyout;
            hresp <= 1'b0;
        end
    end

    // ==========================================
    // read mux; unmapped addresses read zero
    always_comb begin
        channel_config_s c;
        c = cfg[channel_of(req.index)];
        read_data = 32'h00000000;
        if (req.in_range) begin
            for (int k = 0; k < 4; k++) begin
                if (req.index == IDX_INPUT_LEVEL_CH63_48 + 10'(2 * k)) begin
                    read_data[15:0] = word_of(debounced, k);
                end
                if (req.index == IDX_CHANGE_FLAGS_CH63_48 + 10'(2 * k)) begin
                    read_data[15:0] = word_of(flags, k);
                end
            end
            if (req.index == IDX_BOARD_CONTROL_STATUS) begin
                read_data[CSR_CLEAR_FLAGS_BIT] = clear_pending;
            end
            if (req.index >= IDX_CHANNEL_CONFIG_BASE && req.index <= IDX_CHANNEL_CONFIG_LAST
                && !req.index[0]) begin
                read_data[EDGE_SELECT_HIGH_BIT:EDGE_SELECT_LOW_BIT] = c.edge_sel;
                read_data[FILTER_TIME_MSB:0] = c.filter_time_select;
            end
            if (req.index == IDX_IRQ_STATUS) begin
                read_data[1:0] = irq_status;
            end
            if (req.index == IDX_IRQ_MASK) begin
                read_data[1:0] = irq_mask;
            end
        end
    end

    // ==========================================
    // debounce, change detection and flags
    always_comb begin
        logic [63:0] clr;
        logic accept;
        logic level;
        clr = 64'h0;
        accept = 1'b0;
        level = 1'b0;
        next_tick_count = ms_tick ? 32'h00000000 : tick_count + 32'h00000001;
        next_debounced = debounced;
        next_cfg = cfg;
        change_set = 64'h0;
        for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
            level = field_in[ch];
            accept = 1'b0;
            next_count[ch] = count[ch];
            // a level that bounces back before the filter time restarts the count
            if (level == debounced[ch]) begin
                next_count[ch] = 11'h000;
            end else if (ms_tick) begin
                // the first tick after a change is partial, so one extra tick
                // guarantees the level stood for the full filter time
                if (count[ch] == {1'b0, cfg[ch].filter_time_select} + 11'h001) begin
                    accept = 1'b1;
                    next_count[ch] = 11'h000;
                end else begin
                    next_count[ch] = count[ch] + 11'h001;
                end
            end
            if (accept) begin
                next_debounced[ch] = level;
            end
            unique case (cfg[ch].edge_sel)
                edge_off: change_set[ch] = 1'b0;
                edge_falling: change_set[ch] = accept && !level;
                edge_rising: change_set[ch] = accept && level;
                edge_both: change_set[ch] = accept;
            endcase
        end
        // level words have no write path at all
        if (wr && widx >= IDX_CHANNEL_CONFIG_BASE && widx <= IDX_CHANNEL_CONFIG_LAST
            && !widx[0]) begin
            next_cfg[channel_of(widx)].edge_sel =
                edge_select_e'(hwdata[EDGE_SELECT_HIGH_BIT:EDGE_SELECT_LOW_BIT]);
            next_cfg[channel_of(widx)].filter_time_select = hwdata[FILTER_TIME_MSB:0];
        end
        for (int k = 0; k < 4; k++) begin
            if (wr && widx == IDX_CHANGE_FLAGS_CH63_48 + 10'(2 * k)) begin
                clr[63 - 16 * k -: 16] = ~hwdata[15:0];
            end
        end
        if (clear_pending) begin
            clr = 64'hffffffffffffffff;
        end
        next_clear_pending = wr && widx == IDX_BOARD_CONTROL_STATUS
            && hwdata[CSR_CLEAR_FLAGS_BIT];
        next_flags = (flags & ~clr) | change_set;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        if (wr && widx == IDX_IRQ_MASK) begin
            next_irq_mask = hwdata[1:0];
        end
        if (wr && widx == IDX_IRQ_STATUS) begin
            next_irq_status = irq_status & ~hwdata[1:0];
        end
        // set beats write-one-to-clear in the same cycle
        next_irq_status[IRQ_CHANGE_BIT] = next_irq_status[IRQ_CHANGE_BIT] | (|change_set);
        next_irq_status[IRQ_OVERRUN_BIT] = next_irq_status[IRQ_OVERRUN_BIT]
            | (|(change_set & flags));
        next_irq = |(irq_status & irq_mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_count <= 32'h00000000;
            debounced <= LEVEL_RESET;
            flags <= FLAGS_RESET;
            clear_pending <= 1'b0;
            irq_status <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            irq <= 1'b0;
            change_strobe <= 64'h0;
            for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
                count[ch] <= 11'h000;
                cfg[ch] <= '0;
            end
        end else begin
            tick_count <= next_tick_count;
            debounced <= next_debounced;
            flags <= next_flags;
            clear_pending <= next_clear_pending;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
            change_strobe <= change_set;
            for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
                count[ch] <= next_count[ch];
                cfg[ch] <= next_cfg[ch];
            end
        end
    end
endmodule // input_change_flags
`default_nettype wire

/* verif/input_change_flags_checker.sv */
// Purpose: timing checks on the bus and event ports
// Assumes: hready is fed from hreadyout
// Notes: bound into every instance of the block
`timescale 1ns/1ps
`default_nettype none
module input_change_flags_checker #(
    parameter int unsigned ms_cycles = 4
) (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, low active
    input wire logic hsel, // select
    input wire logic [1:0] htrans, // transfer type
    input wire logic hready, // bus ready
    input wire logic [31:0] hrdata, // read data
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic [63:0] change_strobe, // change pulses
    input wire logic irq // interrupt
);
    // ==========
    // properties
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic take = hsel && htrans[1] && hready && hreadyout;
    // strobes only come on the millisecond tick, so their spacing is whole ticks
    logic [31:0] since_strobe;
    logic seen_strobe;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_strobe <= 32'h00000000;
            seen_strobe <= 1'b0;
        end else begin
            since_strobe <= (|change_strobe) ? 32'h00000001 : since_strobe + 32'h00000001;
            seen_strobe <= seen_strobe || (|change_strobe);
        end
    end
    strobe_tick_a: assert property (|change_strobe && seen_strobe |->
        (since_strobe % ms_cycles) == 32'h00000000) else $error("strobe off the tick");
    resp_okay_a: assert property (!hresp) else $error("bad response");
    one_wait_a: assert property (take |=> !hreadyout ##1 hreadyout)
        else $error("wait state wrong");
    quiet_bus_a: assert property (hreadyout && !take |=> hreadyout)
        else $error("ready dropped");
    rdata_hold_a: assert property (!$stable(hrdata) |-> hreadyout && !$past(hreadyout))
        else $error("read data moved");
    strobe_once_a: assert property (|change_strobe |=>
        (change_strobe & $past(change_strobe)) == 64'h0) else $error("strobe too long");
    irq_rise_a: assert property ($rose(irq) |-> $past(|change_strobe)
        || !$past(hreadyout) || !$past(hreadyout, 2)) else $error("irq rose alone");
    irq_fall_a: assert property ($fell(irq) |-> !$past(hreadyout)
        || !$past(hreadyout, 2)) else $error("irq fell alone");
    reset_idle_a: assert property ($rose(hresetn) |->
        hreadyout && !irq && change_strobe == 64'h0) else $error("not idle after reset");
    cover property (|change_strobe);
    cover property ($rose(irq));
    cover property ($fell(irq));
endmodule // input_change_flags_checker
bind input_change_flags input_change_flags_checker #(.ms_cycles(ms_cycles)) chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .change_strobe(change_strobe), .irq(irq));
`default_nettype wire

/* verif/field_lines.sv */
// Purpose: field input lines with optional contact bounce
// Assumes: lines change only after a clock edge
// Notes: a bounce is one clock back at the old level
`timescale 1ns/1ps
`default_nettype none
module field_lines (
    input wire logic hclk, // clock
    input wire logic bounce, // bounce after each change
    input wire logic [63:0] level, // settled level
    output logic [63:0] field_in // lines to the block
);
    logic [63:0] prev = 64'h0, held = 64'h0;
    logic [1:0] cnt = 2'h0;
    always @(posedge hclk) begin
        prev <= level;
        if (level != prev) begin
            held <= prev;
            cnt <= bounce ? 2'h3 : 2'h0;
        end else if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
        end
    end
    // bounce kept shorter than a tick so the filter must restart
    assign field_in = (cnt == 2'h2) ? held : level;
endmodule // field_lines
`default_nettype wire

/* verif/testbench.sv */
// Purpose: self-checking bench for level words and change flags
// Assumes: ms_cycles cut to 4, so a millisecond is 4 clocks
// Notes: reads are compared from a queue by a monitor
`timescale 1ns/1ps
`default_nettype none
module testbench import input_flags_pkg::*; ;
    localparam int MS = 4;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, bounce = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, irq, rd_ph = 1'b0;
    logic [63:0] level = 64'h0, field_in, change_strobe, pat, flg;
    logic [31:0] exp_q[$];
    int n_fail = 0, n_tests = 0, t;
    input_change_flags #(.ms_cycles(MS)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .field_in(field_in),
        .change_strobe(change_strobe), .irq(irq));
    field_lines line_u (.hclk(hclk), .bounce(bounce), .level(level), .field_in(field_in));
    initial forever #2.5 hclk = ~hclk;
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge hclk); while (!hreadyout);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!hreadyout);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask
    // channel 63 sits in the top bit of the first word
    task automatic rd_all(input logic [9:0] base, input logic [63:0] v);
        for (int w = 0; w < 4; w++)
            rd({base + IDX_WORD_STEP * 10'(w), 2'b00}, {16'h0, v[63 - 16 * w -: 16]});
    endtask
    always @(posedge hclk) begin
        if (rd_ph && hreadyout) begin
            check({32'h0, hrdata}, {32'h0, exp_q.pop_front()});
            rd_ph = 1'b0;
        end
        if (hsel && htrans[1] && hreadyout && !hwrite)
            rd_ph = 1'b1;
    end
    initial begin
        #20000;
        n_fail++;
        give_verdict();
    end
    initial begin
        void'($urandom(76516));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_all(IDX_INPUT_LEVEL_CH63_48, 64'h0);
        rd_all(IDX_CHANGE_FLAGS_CH63_48, 64'h0);
        $display("reset test done");
        for (int n = 0; n < 64; n++)
            bus({IDX_CHANNEL_CONFIG_BASE + 10'(2 * n), 2'b00}, 1'b1, {16'h0, 2'(n), 14'h2});
        pat = {$urandom, $urandom} | 64'h4;
        bounce <= 1'b1;
        level <= pat;
        t = 0;
        while (change_strobe === 64'h0 && t < 40) begin
            @(posedge hclk);
            t++;
        end
        check(change_strobe, pat & 64'hcccc_cccc_cccc_cccc);
        check(64'(t >= 3 * MS + 4 && t <= 4 * MS + 4), 64'h1);
        repeat (4 * MS) @(posedge hclk);
        flg = pat & 64'hcccc_cccc_cccc_cccc;
        rd_all(IDX_INPUT_LEVEL_CH63_48, pat);
        rd_all(IDX_CHANGE_FLAGS_CH63_48, flg);
        check({63'h0, irq}, 64'h0);
        level <= 64'h0;
        repeat (6 * MS) @(posedge hclk);
        flg |= pat & 64'haaaa_aaaa_aaaa_aaaa;
        rd_all(IDX_CHANGE_FLAGS_CH63_48, flg);
        bus({IDX_INPUT_LEVEL_CH63_48, 2'b00}, 1'b1, 32'hffff);
        rd_all(IDX_INPUT_LEVEL_CH63_48, 64'h0);
        $display("change test done");
        bus({IDX_CHANGE_FLAGS_CH63_48, 2'b00}, 1'b1, 32'h00ff);
        flg[63:56] = 8'h0;
        rd_all(IDX_CHANGE_FLAGS_CH63_48, flg);
        bus({IDX_BOARD_CONTROL_STATUS, 2'b00}, 1'b1, 32'h1 << CSR_CLEAR_FLAGS_BIT);
        rd({IDX_BOARD_CONTROL_STATUS, 2'b00}, 32'h0);
        rd_all(IDX_CHANGE_FLAGS_CH63_48, 64'h0);
        rd(12'h300, 32'h0);
        $display("clear test done");
        rd({IDX_IRQ_STATUS, 2'b00}, {30'h0, |(pat & 64'h8888_8888_8888_8888), 1'b1});
        bus({IDX_IRQ_MASK, 2'b00}, 1'b1, 32'h1);
        repeat (2) @(posedge hclk);
        check({63'h0, irq}, 64'h1);
        bus({IDX_IRQ_STATUS, 2'b00}, 1'b1, 32'h3);
        repeat (2) @(posedge hclk);
        check({63'h0, irq}, 64'h0);
        rd({IDX_IRQ_STATUS, 2'b00}, 32'h0);
        $display("interrupt test done");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
